// [verification/scws_core_asserts.sv]
// scws_chk: port checker for scws_core
// assumes: bound to every scws_core instance
`timescale 1ns/1ns
module scws_chk
  import scws_pkg::*;
(
  input wire logic                   CLK_SYS, RST_N, SELECT_N, SERIAL_OUT,
  input wire logic                   SERIAL_OUT_OE, RESTART_MODE, CMD_VALID, FRAME_ERR,
  input wire logic [SCWS_ADDR_W-1:0] CMD_ADDR,
  input wire logic [SCWS_DATA_W-1:0] CMD_DATA
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  oe_select_a: assert property (SERIAL_OUT_OE == !SELECT_N)
    else $error("output enable not tied to select");
  valid_pulse_a: assert property (CMD_VALID |=> !CMD_VALID)
    else $error("command valid longer than one cycle");
  valid_after_a: assert property (CMD_VALID |-> SELECT_N && $past(SELECT_N, 3))
    else $error("command valid while selected");
  valid_delay_a: assert property (CMD_VALID |-> !$past(SELECT_N, 5) || !$past(SELECT_N, 6))
    else $error("command valid at wrong delay");
  restart_drop_a: assert property (RESTART_MODE && $rose(SELECT_N) |=> !CMD_VALID [*6])
    else $error("frame decoded in restart");
  err_drop_a: assert property ($rose(FRAME_ERR) |-> !CMD_VALID)
    else $error("bad frame decoded");
  fields_hold_a: assert property ($changed({CMD_ADDR, CMD_DATA}) |-> CMD_VALID)
    else $error("fields moved without decode");
  err_out_a: assert property ($fell(SELECT_N) && !RESTART_MODE |-> SERIAL_OUT == FRAME_ERR)
    else $error("first output bit not error flag");
  cover property (CMD_VALID);
  cover property ($rose(FRAME_ERR));
  cover property (RESTART_MODE && $rose(SELECT_N));
endmodule : scws_chk
bind scws_core scws_chk scws_chk_i (.*);

// [verification/scws_host.sv]
// scws_host: host master model driving frames on the serial link
// assumes: link clock half period 3 ns, made only inside frames
`timescale 1ns/1ns
module scws_host (
  output logic     sclk,
  output logic     select_n,
  output logic     serial_in,
  input wire logic serial_out
);
  logic err;
  logic [15:0] rx;
  initial begin
    rx = 16'h0000;
    sclk = 1'b0;
    select_n = 1'b1;
    serial_in = 1'b0;
    err = 1'b0;
  end
  task automatic frame(input logic [15:0] w, input int n);
    select_n = 1'b0;
    #20 err = serial_out;
    for (int i = 0; i < n; i++) begin
      rx[15-i] = serial_out;
      sclk = 1'b1;
      #1 serial_in = w[15-i];
      #2 sclk = 1'b0;
      #3;
    end
    #20 select_n = 1'b1;
    serial_in = ~serial_in;
  endtask : frame
endmodule : scws_host

// [verification/tb.sv]
// tb: scenario bench for scws_core
// assumes: scws_host model drives the serial link
`timescale 1ns/1ns
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin errors++; \
  $display("unexpected at %0t: got %h exp %h", $time, a, e); end end
module tb;
  import scws_pkg::*;
  logic                   CLK_SYS, RST_N, SCLK, SELECT_N, SERIAL_IN, SERIAL_OUT;
  logic                   SERIAL_OUT_OE, RESTART_MODE, CMD_VALID, CMD_WRITE, FRAME_ERR, got;
  logic [SCWS_ADDR_W-1:0] CMD_ADDR;
  logic [SCWS_DATA_W-1:0] RESP_DATA, CMD_DATA;
  logic [15:0]            cap;
  int                     errors, n_checks, cyc;
  scws_core scws_core_i (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .SCLK(SCLK), .SELECT_N(SELECT_N),
                         .SERIAL_IN(SERIAL_IN), .SERIAL_OUT(SERIAL_OUT),
                         .SERIAL_OUT_OE(SERIAL_OUT_OE), .RESTART_MODE(RESTART_MODE),
                         .RESP_DATA(RESP_DATA), .CMD_VALID(CMD_VALID), .CMD_ADDR(CMD_ADDR),
                         .CMD_WRITE(CMD_WRITE), .CMD_DATA(CMD_DATA), .FRAME_ERR(FRAME_ERR));
  scws_host scws_host_i (.sclk(SCLK), .select_n(SELECT_N), .serial_in(SERIAL_IN),
                         .serial_out(SERIAL_OUT));
  initial begin
    CLK_SYS = 1'b0;
    forever #4 CLK_SYS = ~CLK_SYS;
  end
  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  always @(posedge CLK_SYS) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      close_out();
    end
  end
  // frame then watch ten cycles for a decode
  task automatic run(input logic [15:0] w, input int n);
    got = 1'b0;
    scws_host_i.frame(w, n);
    repeat (10) begin
      @(negedge CLK_SYS);
      if (CMD_VALID === 1'b1) begin
        got = 1'b1;
        cap = {CMD_DATA, CMD_WRITE, CMD_ADDR};
      end
    end
  endtask : run
  task automatic good_frames;
    logic [15:0] tbl [2] = '{16'hA583, 16'h3C7F};
    foreach (tbl[i]) begin
      run(tbl[i], 16);
      `CHK(got, 1'b1)
      `CHK(cap, tbl[i])
      `CHK(FRAME_ERR, 1'b0)
      `CHK(scws_host_i.rx[14:0], {RESP_DATA[6:0], 8'h00})
    end
  endtask : good_frames
  task automatic bad_count;
    run(16'hFFFF, 15);
    `CHK(got, 1'b0)
    `CHK(FRAME_ERR, 1'b1)
    run(16'h0000, 0);
    `CHK(scws_host_i.err, 1'b1)
  endtask : bad_count
  task automatic restart_frame;
    @(negedge CLK_SYS) RESTART_MODE = 1'b1;
    run(16'h1234, 16);
    `CHK(got, 1'b0)
    `CHK(cap, 16'h3C7F)
    @(negedge CLK_SYS) RESTART_MODE = 1'b0;
  endtask : restart_frame
  initial begin
    RST_N = 1'b0;
    RESTART_MODE = 1'b0;
    RESP_DATA = 8'h5A;
    repeat (2) @(negedge CLK_SYS);
    RST_N = 1'b1;
    run(16'h0000, 0);
    good_frames();
    bad_count();
    good_frames();
    restart_frame();
    good_frames();
    close_out();
  end
endmodule : tb

// [verilog/scws_core.sv]
// scws_core: serial control word slave, system side plus link shifter
// assumes: host drives sclk, select_n and serial_in; command outputs settle on CLK_SYS
`timescale 1ns/1ns
module scws_core
  import scws_pkg::*;
(
  input  wire logic                              CLK_SYS,
  input  wire logic                              RST_N,
  input  wire logic                              SCLK,
  input  wire logic                              SELECT_N,
  input  wire logic                              SERIAL_IN,
  output logic                                   SERIAL_OUT,
  output logic                                   SERIAL_OUT_OE,
  input  wire logic                              RESTART_MODE,
  input  wire logic [scws_pkg::SCWS_DATA_W-1:0]  RESP_DATA,
  output logic                                   CMD_VALID,
  output logic [scws_pkg::SCWS_ADDR_W-1:0]       CMD_ADDR,
  output logic                                   CMD_WRITE,
  output logic [scws_pkg::SCWS_DATA_W-1:0]       CMD_DATA,
  output logic                                   FRAME_ERR
);

  // ----------------------------------------------------------------
  // link-side shifter (runs on the host's serial clock)
  // ----------------------------------------------------------------
  logic        tx_bit;
  logic [15:0] rx_word;
  logic [4:0]  edge_cnt;
  logic [15:0] resp_word;
  logic        err_q;

  // error flag reported first, then response data, own word only
  assign resp_word = {err_q, RESP_DATA[6:0], SCWS_DATA_RST};

  scws_shifter u_shift (
    .sclk           (SCLK),
    .select_n       (SELECT_N),
    .serial_in      (SERIAL_IN),
    .resp_word      (resp_word),
    .serial_out_bit (tx_bit),
    .rx_word        (rx_word),
    .edge_cnt       (edge_cnt)
  );

  // output is driven only during a frame; released otherwise
  assign SERIAL_OUT    = tx_bit;
  assign SERIAL_OUT_OE = ~SELECT_N;

  // ----------------------------------------------------------------
  // synchronise select and restart into CLK_SYS
  // ----------------------------------------------------------------
  logic sel_s1_q, sel_s2_q, sel_s3_q;
  logic rst_s1_q, rst_s2_q;

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      sel_s1_q <= 1'b1;
      sel_s2_q <= 1'b1;
      sel_s3_q <= 1'b1;
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      sel_s1_q <= SELECT_N;
      sel_s2_q <= sel_s1_q;
      sel_s3_q <= sel_s2_q;
      rst_s1_q <= RESTART_MODE;
      rst_s2_q <= rst_s1_q;
    end
  end

  logic sel_fall;
  logic sel_rise;
  assign sel_fall = sel_s3_q & ~sel_s2_q;
  assign sel_rise = ~sel_s3_q & sel_s2_q;

  // ----------------------------------------------------------------
  // frame tracking
  // ----------------------------------------------------------------
  scws_state_t state_q;
  logic        restart_seen_q;

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      state_q <= SCWS_ST_IDLE;
    end else begin
      unique case (state_q)
        SCWS_ST_IDLE:   if (sel_fall) state_q <= SCWS_ST_FRAME;
        SCWS_ST_FRAME:  if (sel_rise) state_q <= SCWS_ST_DECODE;
        SCWS_ST_DECODE: state_q <= SCWS_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      restart_seen_q <= 1'b0;
    end else if (sel_fall) begin
      restart_seen_q <= rst_s2_q;
    end else if (state_q == SCWS_ST_FRAME && rst_s2_q) begin
      restart_seen_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // decode after select rises; link data is stable then
  // ----------------------------------------------------------------
  logic count_ok;
  logic count_full;
  assign count_full = (edge_cnt == SCWS_BITS_FULL);
  assign count_ok   = count_full || (edge_cnt == SCWS_BITS_NONE);

  logic                   valid_q;
  logic [SCWS_ADDR_W-1:0] addr_q;
  logic                   write_q;
  logic [SCWS_DATA_W-1:0] data_q;

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      valid_q <= 1'b0;
      addr_q  <= SCWS_ADDR_RST;
      write_q <= 1'b0;
      data_q  <= SCWS_DATA_RST;
    end else begin
      valid_q <= 1'b0;
      if (state_q == SCWS_ST_DECODE && count_full && !restart_seen_q && !rst_s2_q) begin
        valid_q <= 1'b1;
        addr_q  <= rx_word[SCWS_ADDR_LSB +: SCWS_ADDR_W];
        write_q <= rx_word[SCWS_RW_BIT];
        data_q  <= rx_word[SCWS_DATA_LSB +: SCWS_DATA_W];
      end
    end
  end

  // ----------------------------------------------------------------
  // error flag, reported in the next frame's first bit
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      err_q <= 1'b0;
    end else if (state_q == SCWS_ST_DECODE) begin
      err_q <= !count_ok || restart_seen_q || rst_s2_q;
    end
  end

  assign CMD_VALID = valid_q;
  assign CMD_ADDR  = addr_q;
  assign CMD_WRITE = write_q;
  assign CMD_DATA  = data_q;
  assign FRAME_ERR = err_q;

endmodule : scws_core

// [verilog/scws_pkg.sv]
// scws_pkg: constants and types for the serial control word slave
// assumes: shared by the link-side shifter and the system-side core
package scws_pkg;

  // ----------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------
  localparam int          SCWS_WORD_W   = 16;
  localparam int          SCWS_ADDR_LSB = 0;
  localparam int          SCWS_ADDR_W   = 7;
  localparam int          SCWS_RW_BIT   = 7;
  localparam int          SCWS_DATA_LSB = 8;
  localparam int          SCWS_DATA_W   = 8;
  localparam logic [4:0]  SCWS_BITS_FULL = 5'h10;
  localparam logic [4:0]  SCWS_BITS_NONE = 5'h00;
  localparam int          SCWS_ERR_BIT  = 15;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] SCWS_RESP_RST = 16'h0000;
  localparam logic [6:0]  SCWS_ADDR_RST = 7'h00;
  localparam logic [7:0]  SCWS_DATA_RST = 8'h00;

  typedef enum logic [1:0] {
    SCWS_ST_IDLE,
    SCWS_ST_FRAME,
    SCWS_ST_DECODE
  } scws_state_t;

endpackage : scws_pkg

// [verilog/scws_shifter.sv]
// scws_shifter: shift registers on the serial clock
// assumes: sclk stops while select_n is high; select_n is the frame signal
`timescale 1ns/1ns
module scws_shifter
  import scws_pkg::*;
(
  input  wire logic        sclk,
  input  wire logic        select_n,
  input  wire logic        serial_in,
  input  wire logic [15:0] resp_word,
  output logic             serial_out_bit,
  output logic [15:0]      rx_word,
  output logic [4:0]       edge_cnt
);

  logic [15:0] rx_q;
  logic [15:0] tx_q;
  logic [4:0]  cnt_q;

  // ----------------------------------------------------------------
  // receive on falling edge
  // ----------------------------------------------------------------
  always_ff @(negedge sclk) begin
    if (!select_n) begin
      rx_q <= {rx_q[14:0], serial_in};
    end
  end

  // ----------------------------------------------------------------
  // transmit after rising edge, loaded at frame start
  // ----------------------------------------------------------------
  always_ff @(posedge sclk or negedge select_n) begin
    if (!select_n && !sclk) begin
      tx_q  <= resp_word;
      cnt_q <= SCWS_BITS_NONE;
    end else if (!select_n) begin
      tx_q <= {tx_q[14:0], 1'b0};
      if (!(&cnt_q)) begin
        cnt_q <= cnt_q + 5'h01;
      end
    end
  end

  assign serial_out_bit = tx_q[15];
  assign rx_word        = rx_q;
  assign edge_cnt       = cnt_q;

endmodule : scws_shifter
